/* File: dv/ee_link_props.sv */
// Checker for the two-wire link between the master end and the device end
`timescale 1ns/1ps
module ee_link_props #(
  parameter logic [3:0] DEVICE_TYPE_ID = 4'h5,
  parameter int WRITE_CYCLES = 600
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // Link wires
  input wire logic scl,
  input wire logic sda,
  input wire logic d_sda_oe
);
  // =====================================================================
  // Frame tracking
  logic scl_reg, sda_reg, rd_reg, ack_reg, quiet_reg;
  logic [3:0] bit_reg;
  logic [2:0] byte_reg;
  logic [7:0] sh_reg, sel_reg;
  int busy_reg;
  wire start_w = scl_reg & scl & sda_reg & ~sda;
  wire stop_w = scl_reg & scl & ~sda_reg & sda;
  wire rise_w = ~scl_reg & scl;

  // Counters restart at every Start, so a repeated Start reframes too
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      scl_reg <= 1'b1;
      sda_reg <= 1'b1;
      rd_reg <= 1'b0;
      ack_reg <= 1'b1;
      quiet_reg <= 1'b0;
      bit_reg <= 4'h0;
      byte_reg <= 3'h0;
      sh_reg <= 8'h00;
      sel_reg <= 8'h00;
      busy_reg <= 0;
    end else begin
      scl_reg <= scl;
      sda_reg <= sda;
      if (start_w) begin
        bit_reg <= 4'h0;
        byte_reg <= 3'h0;
        rd_reg <= 1'b0;
        quiet_reg <= 1'b0;
      end else if (rise_w) begin
        sh_reg <= {sh_reg[6:0], sda};
        bit_reg <= (bit_reg == 4'h9) ? 4'h1 : bit_reg + 4'h1;
        if (bit_reg == 4'h7 && byte_reg == 3'h0) begin
          sel_reg <= {sh_reg[6:0], sda};
          rd_reg <= sda;
        end
        if (bit_reg == 4'h8) begin
          ack_reg <= sda;
          if (byte_reg != 3'h7) byte_reg <= byte_reg + 3'h1;
          if (sda && (byte_reg == 3'h0 || rd_reg)) quiet_reg <= 1'b1;
        end
      end
      // Loose window: covers the late start and early end of the write cycle
      if (stop_w && bit_reg == 4'h1 && byte_reg >= 3'h4 && !rd_reg && !ack_reg) begin
        busy_reg <= WRITE_CYCLES;
      end else if (busy_reg != 0) begin
        busy_reg <= busy_reg - 1;
      end
    end
  end

  // =====================================================================
  // Assertions
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  AST_HOLD_WHILE_HIGH: assert property (
    scl && $past(scl) |-> $stable(d_sda_oe)) else $error("device drive moved, clock high");
  AST_WRITE_BITS_FREE: assert property (
    (byte_reg == 3'h0 || !rd_reg) && scl && scl_reg && bit_reg inside {[4'h1:4'h8]}
    |-> !d_sda_oe) else $error("device drove a bit it receives");
  AST_READ_SLOT9_FREE: assert property (
    rd_reg && byte_reg >= 3'h2 && scl && scl_reg && bit_reg == 4'h9 |-> !d_sda_oe)
    else $error("device held the master acknowledge slot");
  AST_TYPE_REFUSED: assert property (
    byte_reg == 3'h1 && bit_reg == 4'h9 && scl && scl_reg
    && sel_reg[7:4] != DEVICE_TYPE_ID |-> !d_sda_oe) else $error("foreign type acknowledged");
  AST_STANDBY_QUIET: assert property (quiet_reg |-> !d_sda_oe)
    else $error("device drove after a refused byte");
  AST_BUSY_QUIET: assert property (busy_reg != 0 |-> !d_sda_oe)
    else $error("device drove during its write cycle");
  AST_ACK_BEGIN: assert property (!rd_reg && $rose(d_sda_oe) |-> bit_reg == 4'h8)
    else $error("acknowledge began outside slot nine");
  AST_ACK_END: assert property (!rd_reg && $fell(d_sda_oe) |-> bit_reg == 4'h9)
    else $error("acknowledge not one bit long");
endmodule : ee_link_props

/* File: dv/testbench.sv */
// Bench: master end and device end joined over the link, checked end to end
`timescale 1ns/1ps
module testbench;
  // =====================================================================
  // Setup
  localparam logic [3:0] TYPE_ID = 4'h5; // Arbitrary type code
  localparam int WCYC = 600; // Longer than one poll byte, so polls see busy
  typedef struct packed {logic nack; logic chk; logic [7:0] data;} note_s;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic cmd_valid = 1'b0;
  logic cmd_start = 1'b0;
  logic cmd_stop = 1'b0;
  logic cmd_read = 1'b0;
  logic cmd_ack = 1'b0;
  logic [7:0] cmd_wdata = 8'h00;
  logic [2:0] strap = 3'h0;
  logic write_protect_in = 1'b0;
  logic cmd_ready, rsp_valid, rsp_nack, write_busy;
  logic [7:0] rsp_rdata, d0;
  logic [7:0] pg [4];
  logic [15:0] a0;
  note_s note_q [$];
  note_s note;
  int err_count = 0;
  int samples_checked = 0;

  // 25 MHz system clock
  always #20 clk_sys = ~clk_sys;

  // Both ends and the checker on one carrier
  ee_link_if u_ee_link_if ();
  ee_device #(.DEVICE_TYPE_ID(TYPE_ID), .WRITE_CYCLES(WCYC)) u_ee_device (
    .clk_sys(clk_sys), .rst_b(rst_b), .link(u_ee_link_if.device),
    .strap_addr_bit_low(strap[0]), .strap_addr_bit_mid(strap[1]),
    .strap_addr_bit_high(strap[2]), .write_protect_in(write_protect_in),
    .write_busy(write_busy));
  ee_master #(.QUARTER_CYCLES(4)) u_ee_master (
    .clk_sys(clk_sys), .rst_b(rst_b), .link(u_ee_link_if.master), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_start(cmd_start), .cmd_stop(cmd_stop), .cmd_read(cmd_read),
    .cmd_ack(cmd_ack), .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata), .rsp_nack(rsp_nack));
  ee_link_props #(.DEVICE_TYPE_ID(TYPE_ID), .WRITE_CYCLES(WCYC)) u_ee_link_props (
    .clk_sys(clk_sys), .rst_b(rst_b), .scl(u_ee_link_if.scl),
    .sda(u_ee_link_if.sda), .d_sda_oe(u_ee_link_if.d_sda_oe));

  // =====================================================================
  // Reporting and compares
  task automatic final_report();
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : final_report

  task automatic mism(input string msg);
    err_count++;
    $display("unexpected at %0t: %s", $time, msg);
  endtask : mism

  task automatic hang();
    mism("wait ran out");
    final_report();
  endtask : hang

  task automatic cmp_bit(input logic got, input logic exp, input string what);
    samples_checked++;
    if (got !== exp) mism(what);
  endtask : cmp_bit

  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) mism("read byte");
  endtask : cmp_byte

  // =====================================================================
  // Command driver: one byte per command, note pushed before the take
  task automatic xfer(input logic st, input logic sp, input logic rd, input logic ak,
                      input logic [7:0] wd, input logic en, input logic [7:0] ed);
    int n;
    n = 0;
    @(posedge clk_sys);
    while (cmd_ready !== 1'b1) begin
      @(posedge clk_sys);
      n++;
      if (n > 4000) hang();
    end
    note_q.push_back('{en, rd, ed});
    cmd_valid <= 1'b1;
    cmd_start <= st;
    cmd_stop <= sp;
    cmd_read <= rd;
    cmd_ack <= ak;
    cmd_wdata <= wd;
    @(posedge clk_sys);
    cmd_valid <= 1'b0;
  endtask : xfer

  task automatic sel(input logic rw, input logic sp, input logic en);
    xfer(1'b1, sp, 1'b0, 1'b0, {TYPE_ID, strap, rw}, en, 8'h00);
  endtask : sel

  task automatic wb(input logic [7:0] d, input logic sp, input logic en);
    xfer(1'b0, sp, 1'b0, 1'b0, d, en, 8'h00);
  endtask : wb

  task automatic rb(input logic ak, input logic sp, input logic [7:0] ed);
    xfer(1'b0, sp, 1'b1, ak, 8'h00, ~ak, ed);
  endtask : rb

  task automatic setaddr(input logic [15:0] a);
    sel(1'b0, 1'b0, 1'b0);
    wb(a[15:8], 1'b0, 1'b0);
    wb(a[7:0], 1'b0, 1'b0);
  endtask : setaddr

  // Drain notes, check the write-cycle flag, then wait for it to clear
  task automatic settle(input logic busy);
    int n;
    n = 0;
    while (note_q.size() != 0 && n < 9000) begin
      @(posedge clk_sys);
      n++;
    end
    repeat (8) @(posedge clk_sys);
    cmp_bit(write_busy, busy, "write cycle flag");
    while (write_busy !== 1'b0 && n < 9000) begin
      @(posedge clk_sys);
      n++;
    end
    if (n >= 9000) hang();
  endtask : settle

  // Each response is matched against the oldest note
  always @(posedge clk_sys) begin
    if (rsp_valid === 1'b1) begin
      if (note_q.size() == 0) begin
        mism("response without a note");
      end else begin
        note = note_q.pop_front();
        cmp_bit(rsp_nack, note.nack, "acknowledge level");
        if (note.chk) cmp_byte(rsp_rdata, note.data);
      end
    end
  end

  // =====================================================================
  // Main sequence
  initial begin
    void'($urandom(32'h48e3));
    a0 = {2'b01, 13'($urandom), 1'b0};
    d0 = 8'($urandom);
    foreach (pg[i]) pg[i] = 8'($urandom);
    @(posedge clk_sys);
    strap <= 3'($urandom);
    repeat (19) @(posedge clk_sys);
    rst_b <= 1'b1;
    // Foreign strap codes and a foreign type code are refused
    for (int i = 1; i < 8; i++) begin
      xfer(1'b1, 1'b1, 1'b0, 1'b0, {TYPE_ID, strap ^ 3'(i), 1'b0}, 1'b1, 8'h00);
    end
    xfer(1'b1, 1'b1, 1'b0, 1'b0, {~TYPE_ID, strap, 1'b1}, 1'b1, 8'h00);
    // Byte write, polled while busy, then a Stop after a bare select
    setaddr(a0);
    wb(d0, 1'b1, 1'b0);
    sel(1'b0, 1'b1, 1'b1);
    settle(1'b1);
    sel(1'b0, 1'b1, 1'b0);
    settle(1'b0);
    // Page write that runs past the row end wraps inside the row
    setaddr(16'h003e);
    for (int i = 0; i < 4; i++) wb(pg[i], 1'(i == 3), 1'b0);
    sel(1'b0, 1'b1, 1'b1);
    settle(1'b1);
    // Protected write is refused, reads still run
    write_protect_in <= 1'b1;
    setaddr(a0);
    wb(~d0, 1'b1, 1'b1);
    settle(1'b0);
    setaddr(a0);
    sel(1'b1, 1'b0, 1'b0);
    rb(1'b0, 1'b1, d0);
    write_protect_in <= 1'b0;
    // Sequential read over the top address, then a current-address read
    setaddr(16'h7fff);
    sel(1'b1, 1'b0, 1'b0);
    rb(1'b1, 1'b0, 8'hff);
    rb(1'b0, 1'b1, pg[2]);
    sel(1'b1, 1'b0, 1'b0);
    rb(1'b0, 1'b1, pg[3]);
    setaddr(16'h003e);
    sel(1'b1, 1'b0, 1'b0);
    rb(1'b1, 1'b0, pg[0]);
    rb(1'b1, 1'b0, pg[1]);
    rb(1'b0, 1'b1, 8'hff);
    settle(1'b0);
    final_report();
  end
endmodule : testbench

/* File: src/ee_device.sv */
// Serial EEPROM device end: select decode, addressing, page write, reads
//
// Operation
// - Select byte MSB first: type, strap field
// - Respond only when strap field matches pins
// - Select bit zero: one reads, zero writes
// - Ack on match, else standby until Start
// - Write select then two acked address bytes
// - Fifteen-bit address, high byte sent first
// - Protect pin high: ack address, nack data
// - Write cycle only on Stop in slot ten
// - Busy: data line released, requests ignored
// - Byte write: select, address, one byte, Stop
// - Page write up to 64 bytes, one row
// - Write data bumps only six low bits
// - Master avoids overrunning the current row
// - Polling: nack while busy, ack when ready
// - Reads run whatever the protect pin says
// - Random read: dummy write, restart, read select
// - Restart repeats same seven select bits
// - Current read returns counter byte, then increments
// - Master acks to continue, nack then Stop
// - Read counter wraps from top to zero
// - Master nack after read byte ends transfer
// - Floating strap pins compare as zero; the pins have no pull-down here and feed the sync flops as driven
`timescale 1ns/1ps
`include "ee_link_regs.svh"
module ee_device #(
  parameter int ADDR_W = `EE_ADDR_BITS,
  parameter logic [3:0] DEVICE_TYPE_ID = 4'h5, // Arbitrary value
  parameter int WRITE_CYCLES = `EE_WRITE_CYCLES
) (
  // System clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // Two-wire link
  ee_link_if.device link,
  // Straps and protection
  input wire logic strap_addr_bit_low,
  input wire logic strap_addr_bit_mid,
  input wire logic strap_addr_bit_high,
  input wire logic write_protect_in,
  // Status
  output logic write_busy
);

  localparam int PB = `EE_PAGE_BITS;
  localparam int TIMER_W = $clog2(WRITE_CYCLES + 1);
  localparam logic [PB-1:0] PAGE_ONE = PB'(1);

  // =====================================================================
  // Storage
  logic [7:0] mem_arr [2**ADDR_W];
  logic [7:0] page_buf [`EE_PAGE_BYTES];
  logic [`EE_PAGE_BYTES-1:0] page_mask_reg;

  // =====================================================================
  // Link domain state
  ee_link_pkg::dev_state_e state_reg;
  logic [3:0] bit_cnt_reg;
  logic [7:0] shift_reg;
  logic [7:0] addr_hi_reg;
  logic [ADDR_W-1:0] addr_reg;
  logic [7:0] rd_byte_reg;
  logic wp_seen_reg;
  logic sda_oe_reg;
  logic start_tgl_reg;
  logic start_seen_reg;
  logic commit_tgl_reg;
  logic wp_meta_reg;
  logic wp_sync_reg;
  logic [2:0] strap_meta_reg;
  logic [2:0] strap_sync_reg;
  logic busy_meta_reg;
  logic busy_sync_reg;
  logic new_start;
  logic ack_slot;
  logic sel_match;
  logic ack_drive;
  logic commit_armed;

  // =====================================================================
  // System domain state
  logic commit_meta_reg;
  logic commit_sync_reg;
  logic commit_seen_reg;
  logic busy_reg;
  logic [TIMER_W-1:0] timer_reg;
  logic [PB:0] walk_reg;
  logic commit_event;

  // Erased delivery state so that reads of unwritten bytes are defined
  initial begin
    for (int i = 0; i < 2**ADDR_W; i++) begin
      mem_arr[i] = 8'hff;
    end
  end

  // Pin inputs pass two flops on the link clock before use
  always_ff @(posedge link.scl or negedge rst_b) begin
    if (!rst_b) begin
      wp_meta_reg <= 1'b0;
      wp_sync_reg <= 1'b0;
      strap_meta_reg <= 3'h0;
      strap_sync_reg <= 3'h0;
      busy_meta_reg <= 1'b0;
      busy_sync_reg <= 1'b0;
    end else begin
      wp_meta_reg <= write_protect_in;
      wp_sync_reg <= wp_meta_reg;
      strap_meta_reg <= {strap_addr_bit_high, strap_addr_bit_mid, strap_addr_bit_low};
      strap_sync_reg <= strap_meta_reg;
      busy_meta_reg <= busy_reg;
      busy_sync_reg <= busy_meta_reg;
    end
  end

  // Start seen on a falling data line with the clock high; a toggle because
  // the first data bit follows too closely for a two-flop crossing
  always_ff @(negedge link.sda or negedge rst_b) begin
    if (!rst_b) begin
      start_tgl_reg <= 1'b0;
    end else if (link.scl) begin
      start_tgl_reg <= ~start_tgl_reg;
    end
  end

  // Stop in the tenth slot after an accepted data byte launches the write
  always_ff @(posedge link.sda or negedge rst_b) begin
    if (!rst_b) begin
      commit_tgl_reg <= 1'b0;
    end else if (link.scl && commit_armed) begin
      commit_tgl_reg <= ~commit_tgl_reg;
    end
  end

  // Decode helpers
  assign new_start = start_tgl_reg ^ start_seen_reg;
  assign ack_slot = (bit_cnt_reg == `EE_ACK_SLOT);
  assign sel_match = (shift_reg[7:4] == DEVICE_TYPE_ID)
    && (shift_reg[3:1] == strap_sync_reg)
    && !busy_sync_reg;
  assign commit_armed = (state_reg == ee_link_pkg::DEV_WDATA)
    && (bit_cnt_reg == `EE_FIRST_SLOT) && (|page_mask_reg);

  // Acknowledge decision for the ninth slot
  always_comb begin
    ack_drive = 1'b0;
    case (state_reg)
      ee_link_pkg::DEV_SELECT: ack_drive = sel_match;
      ee_link_pkg::DEV_ADDR_HI: ack_drive = 1'b1;
      ee_link_pkg::DEV_ADDR_LO: ack_drive = 1'b1;
      ee_link_pkg::DEV_WDATA: ack_drive = ~wp_seen_reg;
      default: ack_drive = 1'b0;
    endcase
  end

  // Bit counter, shifter and frame state; a Start restarts from any state
  always_ff @(posedge link.scl or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= ee_link_pkg::DEV_IDLE;
      bit_cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      start_seen_reg <= 1'b0;
    end else begin
      start_seen_reg <= start_tgl_reg;
      if (new_start) begin
        state_reg <= ee_link_pkg::DEV_SELECT;
        bit_cnt_reg <= `EE_FIRST_SLOT;
        shift_reg <= {7'h00, link.sda};
      end else if (!ack_slot) begin
        bit_cnt_reg <= bit_cnt_reg + 4'h1;
        shift_reg <= {shift_reg[6:0], link.sda};
      end else begin
        bit_cnt_reg <= 4'h0;
        case (state_reg)
          ee_link_pkg::DEV_SELECT: begin
            if (!sda_oe_reg) begin
              state_reg <= ee_link_pkg::DEV_IDLE;
            end else if (shift_reg[0]) begin
              state_reg <= ee_link_pkg::DEV_RDATA;
            end else begin
              state_reg <= ee_link_pkg::DEV_ADDR_HI;
            end
          end
          ee_link_pkg::DEV_ADDR_HI: state_reg <= ee_link_pkg::DEV_ADDR_LO;
          ee_link_pkg::DEV_ADDR_LO: state_reg <= ee_link_pkg::DEV_WDATA;
          ee_link_pkg::DEV_WDATA: state_reg <= ee_link_pkg::DEV_WDATA;
          ee_link_pkg::DEV_RDATA: begin
            if (link.sda) begin
              state_reg <= ee_link_pkg::DEV_IDLE;
            end
          end
          default: state_reg <= ee_link_pkg::DEV_IDLE;
        endcase
      end
    end
  end

  // Protect pin is remembered from Start through the last address slot
  always_ff @(posedge link.scl or negedge rst_b) begin
    if (!rst_b) begin
      wp_seen_reg <= 1'b0;
    end else if (new_start) begin
      wp_seen_reg <= wp_sync_reg;
    end else if (state_reg == ee_link_pkg::DEV_SELECT
      || state_reg == ee_link_pkg::DEV_ADDR_HI
      || state_reg == ee_link_pkg::DEV_ADDR_LO) begin
      wp_seen_reg <= wp_seen_reg | wp_sync_reg;
    end
  end

  // Address counter and read byte fetch, both on the ninth slot
  always_ff @(posedge link.scl or negedge rst_b) begin
    if (!rst_b) begin
      addr_hi_reg <= 8'h00;
      addr_reg <= '0;
      rd_byte_reg <= 8'h00;
    end else if (!new_start && ack_slot) begin
      case (state_reg)
        ee_link_pkg::DEV_SELECT: begin
          if (sda_oe_reg && shift_reg[0]) begin
            rd_byte_reg <= mem_arr[addr_reg];
            addr_reg <= addr_reg + ADDR_W'(1);
          end
        end
        ee_link_pkg::DEV_ADDR_HI: addr_hi_reg <= shift_reg;
        ee_link_pkg::DEV_ADDR_LO: addr_reg <= ADDR_W'({addr_hi_reg, shift_reg});
        ee_link_pkg::DEV_WDATA: begin
          if (!wp_seen_reg) begin
            addr_reg[PB-1:0] <= addr_reg[PB-1:0] + PAGE_ONE;
          end
        end
        ee_link_pkg::DEV_RDATA: begin
          if (!link.sda) begin
            rd_byte_reg <= mem_arr[addr_reg];
            addr_reg <= addr_reg + ADDR_W'(1);
          end
        end
        default: addr_reg <= addr_reg;
      endcase
    end
  end

  // Page latches; an overrun of the row reuses slots from the row start
  always_ff @(posedge link.scl or negedge rst_b) begin
    if (!rst_b) begin
      page_mask_reg <= '0;
    end else if (!new_start && ack_slot) begin
      if (state_reg == ee_link_pkg::DEV_ADDR_LO) begin
        page_mask_reg <= '0;
      end else if (state_reg == ee_link_pkg::DEV_WDATA && !wp_seen_reg) begin
        page_mask_reg[addr_reg[PB-1:0]] <= 1'b1;
      end
    end
  end

  // Page data array has no reset; the mask says which slots hold data
  always_ff @(posedge link.scl) begin
    if (!new_start && ack_slot && state_reg == ee_link_pkg::DEV_WDATA && !wp_seen_reg) begin
      page_buf[addr_reg[PB-1:0]] <= shift_reg;
    end
  end

  // Data line drive changes on the falling clock edge only
  always_ff @(negedge link.scl or negedge rst_b) begin
    if (!rst_b) begin
      sda_oe_reg <= 1'b0;
    end else if (ack_slot) begin
      sda_oe_reg <= ack_drive;
    end else if (state_reg == ee_link_pkg::DEV_RDATA) begin
      sda_oe_reg <= ~rd_byte_reg[~bit_cnt_reg[2:0]];
    end else begin
      sda_oe_reg <= 1'b0;
    end
  end

  assign link.d_sda_oe = sda_oe_reg;
  assign link.d_sda_out = 1'b0;

  // =====================================================================
  // Write cycle on the system clock; the link clock stops after Stop
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      commit_meta_reg <= 1'b0;
      commit_sync_reg <= 1'b0;
      commit_seen_reg <= 1'b0;
    end else begin
      commit_meta_reg <= commit_tgl_reg;
      commit_sync_reg <= commit_meta_reg;
      commit_seen_reg <= commit_sync_reg;
    end
  end

  assign commit_event = commit_sync_reg ^ commit_seen_reg;

  // Busy lasts the full write time from the crossed Stop event
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      busy_reg <= 1'b0;
      timer_reg <= '0;
    end else if (commit_event) begin
      busy_reg <= 1'b1;
      timer_reg <= '0;
    end else if (busy_reg) begin
      if (timer_reg == TIMER_W'(WRITE_CYCLES - 1)) begin
        busy_reg <= 1'b0;
      end else begin
        timer_reg <= timer_reg + TIMER_W'(1);
      end
    end
  end

  // Page copy walk; link side is frozen while busy so its latches are stable
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      walk_reg <= '0;
    end else if (commit_event) begin
      walk_reg <= '0;
    end else if (busy_reg && !walk_reg[PB]) begin
      walk_reg <= walk_reg + (PB + 1)'(1);
    end
  end

  // Array write port, one latched byte per system clock
  always_ff @(posedge clk_sys) begin
    if (busy_reg && !walk_reg[PB] && page_mask_reg[walk_reg[PB-1:0]]) begin
      mem_arr[{addr_reg[ADDR_W-1:PB], walk_reg[PB-1:0]}] <= page_buf[walk_reg[PB-1:0]];
    end
  end

  assign write_busy = busy_reg;

endmodule : ee_device

/* File: src/ee_link_if.sv */
// Two-wire link carrier: serial clock and wired-AND data line
`timescale 1ns/1ps
interface ee_link_if;
  logic scl;
  logic m_sda_out;
  logic m_sda_oe;
  logic d_sda_out;
  logic d_sda_oe;
  logic sda;

  // Pull-up resolution: any enabled driver showing low wins
  assign sda = (m_sda_oe ? m_sda_out : 1'b1) & (d_sda_oe ? d_sda_out : 1'b1);

  modport master (output scl, output m_sda_out, output m_sda_oe, input sda);
  modport device (input scl, input sda, output d_sda_out, output d_sda_oe);
endinterface : ee_link_if

/* File: src/ee_link_pkg.sv */
// Types shared by both ends of the two-wire EEPROM link
package ee_link_pkg;

  // =====================================================================
  // Device end link states
  typedef enum logic [5:0] {
    DEV_IDLE    = 6'h01,
    DEV_SELECT  = 6'h02,
    DEV_ADDR_HI = 6'h04,
    DEV_ADDR_LO = 6'h08,
    DEV_WDATA   = 6'h10,
    DEV_RDATA   = 6'h20
  } dev_state_e;

  // =====================================================================
  // Master end sequencing states
  typedef enum logic [3:0] {
    MST_IDLE  = 4'h1,
    MST_START = 4'h2,
    MST_BITS  = 4'h4,
    MST_STOP  = 4'h8
  } mst_state_e;

endpackage : ee_link_pkg

/* File: src/ee_link_regs.svh */
// Shared constants for the two-wire EEPROM link: slots, page geometry and timing
`ifndef EE_LINK_REGS_SVH
`define EE_LINK_REGS_SVH

// =====================================================================
// Frame layout
`define EE_ACK_SLOT 4'h8
`define EE_FIRST_SLOT 4'h1
`define EE_PAGE_BITS 6
`define EE_PAGE_BYTES 64
`define EE_ADDR_BITS 15

// =====================================================================
// Timing
`define EE_CLK_SYS_PERIOD_NS 40
`define EE_SCL_QUARTER_NS 625
`define EE_SCL_QUARTER_CYCLES \
  ((`EE_SCL_QUARTER_NS + `EE_CLK_SYS_PERIOD_NS - 1) / `EE_CLK_SYS_PERIOD_NS)
`define EE_INTERNAL_WRITE_TIME_NS 5000000
`define EE_WRITE_CYCLES \
  ((`EE_INTERNAL_WRITE_TIME_NS + `EE_CLK_SYS_PERIOD_NS - 1) / `EE_CLK_SYS_PERIOD_NS)

`endif

/* File: src/ee_master.sv */
// Two-wire bus master end: byte-level Start, transfer, acknowledge and Stop
`timescale 1ns/1ps
`include "ee_link_regs.svh"
module ee_master #(
  parameter int QUARTER_CYCLES = `EE_SCL_QUARTER_CYCLES
) (
  // System clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // Two-wire link
  ee_link_if.master link,
  // Command
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic cmd_start,
  input wire logic cmd_stop,
  input wire logic cmd_read,
  input wire logic cmd_ack,
  input wire logic [7:0] cmd_wdata,
  // Response
  output logic rsp_valid,
  output logic [7:0] rsp_rdata,
  output logic rsp_nack
);

  localparam int QW = $clog2(QUARTER_CYCLES + 1);

  ee_link_pkg::mst_state_e state_reg;
  logic [QW-1:0] q_cnt_reg;
  logic [1:0] phase_reg;
  logic [3:0] bit_idx_reg;
  logic stop_reg;
  logic read_reg;
  logic ack_reg;
  logic [7:0] tx_reg;
  logic scl_reg;
  logic sda_oe_reg;
  logic sda_meta_reg;
  logic sda_sync_reg;
  logic tick;
  logic take;
  logic bit_drive;

  // Data line passes two flops before it is sampled
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      sda_meta_reg <= 1'b1;
      sda_sync_reg <= 1'b1;
    end else begin
      sda_meta_reg <= link.sda;
      sda_sync_reg <= sda_meta_reg;
    end
  end

  assign take = cmd_valid && cmd_ready;
  assign tick = (q_cnt_reg == QW'(QUARTER_CYCLES - 1));

  // Drive for the current slot: MSB first, ack slot released or acked
  always_comb begin
    bit_drive = 1'b0;
    if (bit_idx_reg == `EE_ACK_SLOT) begin
      bit_drive = read_reg && ack_reg;
    end else if (!read_reg) begin
      bit_drive = ~tx_reg[~bit_idx_reg[2:0]];
    end
  end

  // Quarter-period divider; the serial clock is this end's own output
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      q_cnt_reg <= '0;
      phase_reg <= 2'h0;
    end else if (state_reg == ee_link_pkg::MST_IDLE || tick) begin
      q_cnt_reg <= '0;
      phase_reg <= (state_reg == ee_link_pkg::MST_IDLE) ? 2'h0 : phase_reg + 2'h1;
    end else begin
      q_cnt_reg <= q_cnt_reg + QW'(1);
    end
  end

  // Command latch
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      stop_reg <= 1'b0;
      read_reg <= 1'b0;
      ack_reg <= 1'b0;
      tx_reg <= 8'h00;
    end else if (take) begin
      stop_reg <= cmd_stop;
      read_reg <= cmd_read;
      ack_reg <= cmd_ack;
      tx_reg <= cmd_wdata;
    end
  end

  // Sequencer: in bit slots quarter 0 sets data, 1 raises clock, 2 samples, 3 lowers; Start and Stop move data in quarter 2
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= ee_link_pkg::MST_IDLE;
      scl_reg <= 1'b1;
      sda_oe_reg <= 1'b0;
      bit_idx_reg <= 4'h0;
      cmd_ready <= 1'b1;
      rsp_valid <= 1'b0;
      rsp_rdata <= 8'h00;
      rsp_nack <= 1'b0;
    end else begin
      rsp_valid <= 1'b0;
      case (state_reg)
        ee_link_pkg::MST_IDLE: begin
          if (take) begin
            cmd_ready <= 1'b0;
            bit_idx_reg <= 4'h0;
            state_reg <= cmd_start ? ee_link_pkg::MST_START : ee_link_pkg::MST_BITS;
          end
        end
        ee_link_pkg::MST_START: begin
          if (tick) begin
            case (phase_reg)
              2'h0: begin
                scl_reg <= 1'b0;
                sda_oe_reg <= 1'b0;
              end
              2'h1: scl_reg <= 1'b1;
              2'h2: sda_oe_reg <= 1'b1;
              default: begin
                scl_reg <= 1'b0;
                state_reg <= ee_link_pkg::MST_BITS;
              end
            endcase
          end
        end
        ee_link_pkg::MST_BITS: begin
          if (tick) begin
            case (phase_reg)
              2'h0: begin
                scl_reg <= 1'b0;
                sda_oe_reg <= bit_drive;
              end
              2'h1: scl_reg <= 1'b1;
              2'h2: begin
                if (bit_idx_reg == `EE_ACK_SLOT) begin
                  rsp_nack <= sda_sync_reg;
                end else begin
                  rsp_rdata <= {rsp_rdata[6:0], sda_sync_reg};
                end
              end
              default: begin
                scl_reg <= 1'b0;
                bit_idx_reg <= bit_idx_reg + 4'h1;
                if (bit_idx_reg == `EE_ACK_SLOT) begin
                  if (stop_reg) begin
                    state_reg <= ee_link_pkg::MST_STOP;
                  end else begin
                    state_reg <= ee_link_pkg::MST_IDLE;
                    cmd_ready <= 1'b1;
                    rsp_valid <= 1'b1;
                  end
                end
              end
            endcase
          end
        end
        ee_link_pkg::MST_STOP: begin
          if (tick) begin
            case (phase_reg)
              2'h0: begin
                scl_reg <= 1'b0;
                sda_oe_reg <= 1'b1;
              end
              2'h1: scl_reg <= 1'b1;
              2'h2: sda_oe_reg <= 1'b0;
              default: begin
                state_reg <= ee_link_pkg::MST_IDLE;
                cmd_ready <= 1'b1;
                rsp_valid <= 1'b1;
              end
            endcase
          end
        end
        default: state_reg <= ee_link_pkg::MST_IDLE;
      endcase
    end
  end

  assign link.scl = scl_reg;
  assign link.m_sda_oe = sda_oe_reg;
  assign link.m_sda_out = 1'b0;

endmodule : ee_master
